/* hw/i2sst_top.sv */
// Secondary status tracker of a two-wire serial controller.
// Assumes: bus pins arrive asynchronously; address and data byte strobes
// come from the link logic on I_LCLK, spaced at least 8 link cycles apart.
`timescale 1ns/100ps
module i2sst_top
    import i2sst_pkg::*;
(
    input  wire logic             I_MCLK,
    input  wire logic             I_SRST,
    input  wire logic             I_LCLK,
    input  wire logic             I_SCL,
    input  wire logic             I_SDA,
    input  wire logic             I_LNK_ADDR_STB,
    input  wire logic [7:0]       I_LNK_ADDR_BYTE,
    input  wire logic             I_LNK_DATA_STB,
    input  wire logic [7:0]       I_LNK_DATA_BYTE,
    input  wire logic             I_LNK_ARB_LOST,
    input  wire logic             I_START_GEN,
    input  wire logic             I_DATA_WR,
    input  wire logic             I_WB_CYC,
    input  wire logic             I_WB_STB,
    input  wire logic             I_WB_WE,
    input  wire logic [ADR_W-1:0] I_WB_ADR,
    input  wire logic [3:0]       I_WB_SEL,
    input  wire logic [DAT_W-1:0] I_WB_DAT,
    output logic      [DAT_W-1:0] O_WB_DAT,
    output logic                  O_WB_ACK,
    output logic                  O_BUS_BUSY,
    output logic                  O_ROLE,
    output logic                  O_START_SENT,
    output logic      [15:0]      O_SCL_DIV
);

    // One byte step of the check value
    function automatic logic [7:0] chk_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CHK_POLY) : (r << 1);
        end
        return r;
    endfunction : chk_step

    // ---------------- Link clock domain ----------------
    logic [1:0] lrst_reg;
    logic       l_addr_tgl_reg;
    logic       l_data_tgl_reg;
    logic       l_arb_tgl_reg;
    logic [7:0] l_addr_reg;
    logic [7:0] l_data_reg;

    // Reset brought into the link domain
    always_ff @(posedge I_LCLK) begin
        lrst_reg <= {lrst_reg[0], I_SRST};
    end

    // Each strobe flips a toggle; byte held until next strobe
    always_ff @(posedge I_LCLK) begin
        if (lrst_reg[1]) begin
            l_addr_tgl_reg <= 1'b0;
            l_data_tgl_reg <= 1'b0;
            l_arb_tgl_reg  <= 1'b0;
            l_addr_reg     <= 8'h00;
            l_data_reg     <= 8'h00;
        end else begin
            if (I_LNK_ADDR_STB) begin
                l_addr_tgl_reg <= ~l_addr_tgl_reg;
                l_addr_reg     <= I_LNK_ADDR_BYTE;
            end
            if (I_LNK_DATA_STB) begin
                l_data_tgl_reg <= ~l_data_tgl_reg;
                l_data_reg     <= I_LNK_DATA_BYTE;
            end
            if (I_LNK_ARB_LOST) begin
                l_arb_tgl_reg <= ~l_arb_tgl_reg;
            end
        end
    end

    // ---------------- System clock domain ----------------
    // Synchronisers: stage 0 only feeds stage 1; stage 2 is history
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [2:0] at_sync_reg;
    logic [2:0] dt_sync_reg;
    logic [2:0] ar_sync_reg;

    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            at_sync_reg  <= 3'h0;
            dt_sync_reg  <= 3'h0;
            ar_sync_reg  <= 3'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], I_SCL};
            sda_sync_reg <= {sda_sync_reg[1:0], I_SDA};
            at_sync_reg  <= {at_sync_reg[1:0], l_addr_tgl_reg};
            dt_sync_reg  <= {dt_sync_reg[1:0], l_data_tgl_reg};
            ar_sync_reg  <= {ar_sync_reg[1:0], l_arb_tgl_reg};
        end
    end

    // Bus conditions and crossed events
    logic scl_s;
    logic sda_s;
    logic start_ev;
    logic stop_ev;
    logic addr_ev;
    logic data_ev;
    logic arb_ev;
    assign scl_s    = scl_sync_reg[1];
    assign sda_s    = sda_sync_reg[1];
    assign start_ev = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
    assign stop_ev  = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];
    assign addr_ev  = at_sync_reg[1] ^ at_sync_reg[2];
    assign data_ev  = dt_sync_reg[1] ^ dt_sync_reg[2];
    assign arb_ev   = ar_sync_reg[1] ^ ar_sync_reg[2];

    // Software registers
    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [15:0]           own_reg;
    logic [15:0]           clkdiv_reg;
    logic                  en;
    logic                  chk_en;
    assign en     = ctrl_reg[CTRL_EN_BIT];
    assign chk_en = ctrl_reg[CTRL_CHK_BIT];

    // Address decode of the received byte
    logic [6:0] a7;
    logic       rw;
    logic       m_oa1;
    logic       m_oa2;
    logic       m_gc;
    logic       m_host;
    logic       m_dflt;
    assign a7     = l_addr_reg[7:1];
    assign rw     = l_addr_reg[0];
    assign m_oa1  = a7 == own_reg[OA1_LSB +: 7];
    assign m_oa2  = ctrl_reg[CTRL_DUAL_BIT] && a7 == own_reg[OA2_LSB +: 7];
    assign m_gc   = ctrl_reg[CTRL_GC_BIT] && a7 == ADDR_GCALL;
    assign m_host = ctrl_reg[CTRL_TYPE_BIT] && ctrl_reg[CTRL_ARP_BIT] && a7 == ADDR_HOST;
    assign m_dflt = ctrl_reg[CTRL_ARP_BIT] && a7 == ADDR_DFLT;

    // Start-sent flag: set on generated start, cleared by data write
    logic start_sent_reg;
    logic start_sent_d_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST || !en) begin
            start_sent_reg <= 1'b0;
        end else if (I_START_GEN) begin
            start_sent_reg <= 1'b1;
        end else if (I_DATA_WR) begin
            start_sent_reg <= 1'b0;
        end
    end

    // History of start-sent so role is taken only on its rise
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            start_sent_d_reg <= 1'b0;
        end else begin
            start_sent_d_reg <= start_sent_reg;
        end
    end

    // Role: master on start-sent rise, set beats clear
    logic role_reg;
    logic role_set;
    assign role_set = en && start_sent_reg && !start_sent_d_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            role_reg <= 1'b0;
        end else if (role_set) begin
            role_reg <= 1'b1;
        end else if (stop_ev || arb_ev || !en) begin
            role_reg <= 1'b0;
        end
    end

    // Busy follows the pins whether enabled or not
    logic busy_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            busy_reg <= 1'b0;
        end else if (stop_ev) begin
            busy_reg <= 1'b0;
        end else if (!scl_s || !sda_s) begin
            busy_reg <= 1'b1;
        end
    end

    // Address accepted: own role as master, or a slave match
    logic addr_take;
    logic slv_hit;
    logic flag_clr;
    assign slv_hit   = m_oa1 | m_oa2 | m_gc | m_host | m_dflt;
    assign addr_take = addr_ev && en && (role_reg || slv_hit);
    assign flag_clr  = start_ev || stop_ev || !en;

    // Slave match flags, set wins over the bus-event clear
    logic dual_reg;
    logic host_reg;
    logic dflt_reg;
    logic gc_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            dual_reg <= 1'b0;
            host_reg <= 1'b0;
            dflt_reg <= 1'b0;
            gc_reg   <= 1'b0;
        end else if (addr_take && !role_reg) begin
            dual_reg <= m_oa2 && !m_oa1;
            host_reg <= m_host;
            dflt_reg <= m_dflt;
            gc_reg   <= m_gc;
        end else if (flag_clr) begin
            dual_reg <= 1'b0;
            host_reg <= 1'b0;
            dflt_reg <= 1'b0;
            gc_reg   <= 1'b0;
        end
    end

    // Direction from the read/write bit; master sense is inverted
    logic dir_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            dir_reg <= 1'b0;
        end else if (addr_take) begin
            dir_reg <= role_reg ? ~rw : rw;
        end else if (flag_clr || arb_ev) begin
            dir_reg <= 1'b0;
        end
    end

    // Running check value over address and data bytes
    logic [7:0] chk_reg;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST || !chk_en || !en || start_ev) begin
            chk_reg <= CHK_RST;
        end else if (addr_take) begin
            chk_reg <= chk_step(chk_reg, l_addr_reg);
        end else if (data_ev) begin
            chk_reg <= chk_step(chk_reg, l_data_reg);
        end
    end

    // Status word as software sees it
    logic [15:0] sts_word;
    always_comb begin
        sts_word               = 16'h0000;
        sts_word[STS_CHK_LSB +: 8] = chk_en ? chk_reg : CHK_RST;
        sts_word[STS_DUAL_BIT] = dual_reg;
        sts_word[STS_HOST_BIT] = host_reg;
        sts_word[STS_DFLT_BIT] = dflt_reg;
        sts_word[STS_GC_BIT]   = gc_reg;
        sts_word[STS_RSVD_BIT] = RSVD_RST;
        sts_word[STS_DIR_BIT]  = dir_reg;
        sts_word[STS_BUSY_BIT] = busy_reg;
        sts_word[STS_ROLE_BIT] = role_reg;
    end

    // ---------------- Wishbone slave ----------------
    logic req;
    logic wr;
    assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wr  = req && I_WB_WE;

    // Byte-lane merge for the low half-word
    function automatic logic [15:0] lane16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : lane16

    // Control and own address writes
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            ctrl_reg <= CTRL_RST;
            own_reg  <= OWN_RST;
        end else if (wr) begin
            if (I_WB_ADR == OFS_CTRL && I_WB_SEL[0]) begin
                ctrl_reg <= I_WB_DAT[CTRL_WIDTH-1:0];
            end
            if (I_WB_ADR == OFS_OWNADDR) begin
                own_reg <= lane16(own_reg, I_WB_DAT, I_WB_SEL);
            end
        end
    end

    // Divider only changes while disabled, so timing never glitches
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            clkdiv_reg <= CLKDIV_RST;
        end else if (wr && !en && I_WB_ADR == OFS_CLKDIV) begin
            clkdiv_reg <= lane16(clkdiv_reg, I_WB_DAT, I_WB_SEL);
        end
    end

    // Read mux; status offset has no write path at all
    logic [DAT_W-1:0] rd_next;
    always_comb begin
        case (I_WB_ADR)
            OFS_CTRL:    rd_next = {{(DAT_W-CTRL_WIDTH){1'b0}}, ctrl_reg};
            OFS_OWNADDR: rd_next = {16'h0000, own_reg};
            OFS_BUS_STATUS_TWO:    rd_next = {16'h0000, sts_word};
            OFS_CLKDIV:  rd_next = {16'h0000, clkdiv_reg};
            default:     rd_next = 32'h00000000;
        endcase
    end

    // Answer one cycle after the request; unmapped reads zero
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h00000000;
        end else begin
            O_WB_ACK <= req;
            if (req && !I_WB_WE) begin
                O_WB_DAT <= rd_next;
            end
        end
    end

    // Status outputs
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_BUS_BUSY   <= 1'b0;
            O_ROLE       <= 1'b0;
            O_START_SENT <= 1'b0;
            O_SCL_DIV    <= CLKDIV_RST;
        end else begin
            O_BUS_BUSY   <= busy_reg;
            O_ROLE       <= role_reg;
            O_START_SENT <= start_sent_reg;
            O_SCL_DIV    <= clkdiv_reg;
        end
    end

    // ---------------- Checks ----------------
    a_busy_set_low: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (!scl_s || !sda_s) |=> busy_reg)
        else $error("busy not set on low line");

    a_busy_clr_stop: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        stop_ev |=> !busy_reg ##1 !O_BUS_BUSY)
        else $error("busy not cleared by stop");

    a_role_set_start: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (I_START_GEN && en && !I_DATA_WR) |=> ##1 role_reg ##1 O_ROLE)
        else $error("role not set after start sent");

    a_role_clr_evt: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        ((stop_ev || arb_ev || !en) && !role_set) |=> !role_reg)
        else $error("role not cleared");

    a_flags_clr_evt: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (flag_clr && !addr_take) |=> sts_word[7:4] == 4'h0)
        else $error("match flags not cleared");

    a_host_gate_cfg: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        $rose(host_reg) |-> $past(ctrl_reg[CTRL_TYPE_BIT] && ctrl_reg[CTRL_ARP_BIT]))
        else $error("host flag set without host type and ARP");

    a_gc_set_match: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (addr_take && !role_reg && a7 == ADDR_GCALL) |=> gc_reg == $past(ctrl_reg[CTRL_GC_BIT]))
        else $error("general call flag wrong");

    a_dir_clr_evt: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        ((flag_clr || arb_ev) && !addr_take) |=> !dir_reg)
        else $error("direction not cleared");

    a_sts_rsvd_zero: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (O_WB_ACK && $past(I_WB_ADR) == OFS_BUS_STATUS_TWO && !$past(I_WB_WE)) |-> O_WB_DAT[3] == RSVD_RST)
        else $error("reserved status bit not at reset value");

endmodule : i2sst_top

/* hw/i2sst_pkg.sv */
// Constants for the secondary status tracker of the two-wire controller.
// Assumes a 32-bit classic Wishbone register port with byte addresses.
package i2sst_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_OWNADDR = 8'h08;
    localparam logic [7:0] OFS_BUS_STATUS_TWO    = 8'h18;
    localparam logic [7:0] OFS_CLKDIV  = 8'h1c;
    // Control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CHK_BIT  = 1;
    localparam int CTRL_TYPE_BIT = 2;
    localparam int CTRL_ARP_BIT  = 3;
    localparam int CTRL_GC_BIT   = 4;
    localparam int CTRL_DUAL_BIT = 5;
    localparam int CTRL_WIDTH    = 6;
    // Own address register fields (7-bit addresses)
    localparam int OA1_LSB = 1;
    localparam int OA2_LSB = 9;
    // Status register two fields
    localparam int STS_CHK_LSB  = 8;
    localparam int STS_DUAL_BIT = 7;
    localparam int STS_HOST_BIT = 6;
    localparam int STS_DFLT_BIT = 5;
    localparam int STS_GC_BIT   = 4;
    localparam int STS_RSVD_BIT = 3;
    localparam int STS_DIR_BIT  = 2;
    localparam int STS_BUSY_BIT = 1;
    localparam int STS_ROLE_BIT = 0;
    // Reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RST   = 6'h00;
    localparam logic [15:0]           OWN_RST    = 16'h0000;
    localparam logic [15:0]           CLKDIV_RST = 16'h0000;
    localparam logic                  RSVD_RST   = 1'h0;
    localparam logic [7:0]            CHK_RST    = 8'h00;
    // Special bus addresses (7-bit)
    localparam logic [6:0] ADDR_GCALL = 7'h00;
    localparam logic [6:0] ADDR_HOST  = 7'h08;
    localparam logic [6:0] ADDR_DFLT  = 7'h61;
    // Check value polynomial x^8+x^2+x+1
    localparam logic [7:0] CHK_POLY = 8'h07;
    // Bus ports
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
endpackage : i2sst_pkg

/* dv/i2sst_peer.sv */
// Far-side model: peers on the two bus lines plus the link-side byte strobes.
// Assumes one bench process calls its tasks, one at a time.
`timescale 1ns/100ps
module i2sst_peer (
    input  wire logic       i_lclk,
    output logic            o_scl,
    output logic            o_sda,
    output logic            o_addr_stb,
    output logic      [7:0] o_addr_byte,
    output logic            o_data_stb,
    output logic      [7:0] o_data_byte,
    output logic            o_arb_lost
);
    // Lines idle high on their pull-ups
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_addr_stb = 1'b0;
        o_addr_byte = 8'h5a;
        o_data_stb = 1'b0;
        o_data_byte = 8'ha5;
        o_arb_lost = 1'b0;
    end
    // Each level held six link cycles so the synchronisers see it
    task automatic lvl(input logic c, input logic d);
        @(posedge i_lclk);
        o_scl <= c;
        o_sda <= d;
        repeat (6) @(posedge i_lclk);
    endtask : lvl
    // Start or repeated start: data falls while clock high
    task automatic bus_start();
        lvl(o_scl, 1'b1);
        lvl(1'b1, 1'b1);
        lvl(1'b1, 1'b0);
        lvl(1'b0, 1'b0);
    endtask : bus_start
    // Stop: data rises while clock high
    task automatic bus_stop();
        lvl(1'b0, 1'b0);
        lvl(1'b1, 1'b0);
        lvl(1'b1, 1'b1);
    endtask : bus_stop
    // One byte strobe; lane shows no stale value afterwards, then eight idle cycles
    task automatic send(input logic is_addr, input logic [7:0] b);
        @(posedge i_lclk);
        if (is_addr) begin
            o_addr_stb <= 1'b1;
            o_addr_byte <= b;
        end else begin
            o_data_stb <= 1'b1;
            o_data_byte <= b;
        end
        @(posedge i_lclk);
        o_addr_stb <= 1'b0;
        o_data_stb <= 1'b0;
        o_addr_byte <= ~b;
        o_data_byte <= ~b;
        repeat (8) @(posedge i_lclk);
    endtask : send
    // Arbitration loss pulse
    task automatic lose();
        @(posedge i_lclk);
        o_arb_lost <= 1'b1;
        @(posedge i_lclk);
        o_arb_lost <= 1'b0;
        repeat (8) @(posedge i_lclk);
    endtask : lose
endmodule : i2sst_peer

/* dv/tb_top.sv */
// Bench for the secondary status tracker: register port, lines, link strobes.
// Assumes the peer model drives lines and strobes on the link clock.
`timescale 1ns/100ps
module tb_top;
    import i2sst_pkg::*;
    logic        mclk, lclk, srst, scl, sda, astb, dstb, arb;
    logic        start_gen, data_wr, cyc, stb, we, ack, busy, role, sent;
    logic [7:0]  abyte, dbyte, adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] div;
    int          err_total, cmp_count;

    i2sst_top i2sst_top_i (.I_MCLK(mclk), .I_SRST(srst), .I_LCLK(lclk), .I_SCL(scl), .I_SDA(sda),
        .I_LNK_ADDR_STB(astb), .I_LNK_ADDR_BYTE(abyte), .I_LNK_DATA_STB(dstb), .I_LNK_DATA_BYTE(dbyte),
        .I_LNK_ARB_LOST(arb), .I_START_GEN(start_gen), .I_DATA_WR(data_wr), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_BUS_BUSY(busy), .O_ROLE(role), .O_START_SENT(sent),
        .O_SCL_DIV(div));
    i2sst_peer i2sst_peer_i (.i_lclk(lclk), .o_scl(scl), .o_sda(sda), .o_addr_stb(astb),
        .o_addr_byte(abyte), .o_data_stb(dstb), .o_data_byte(dbyte), .o_arb_lost(arb));

    // Main clock 100 ns; link clock 64 ns drifts against it
    always #50 mclk = ~mclk;
    always #32 lclk = ~lclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; held until ack is sampled high, only the watchdog ends a wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // Start-sent or data-written strobe, one cycle wide
    task automatic pulse(input logic s);
        @(posedge mclk);
        if (s) start_gen <= 1'b1;
        else data_wr <= 1'b1;
        @(posedge mclk);
        start_gen <= 1'b0;
        data_wr <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse
    // Bench's own CRC-8, polynomial taken from the constants
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CHK_POLY) : {r[6:0], 1'b0};
        return r;
    endfunction : crc8
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Reset values, ignored writes, divider locked while enabled, unmapped hole
    task automatic t_regs();
        rd(OFS_BUS_STATUS_TWO, 32'h0);
        rd(OFS_CLKDIV, 32'h0);
        wb(1'b1, OFS_BUS_STATUS_TWO, 32'hffff_ffff);
        rd(OFS_BUS_STATUS_TWO, 32'h0);
        wb(1'b1, OFS_CLKDIV, 32'h1234);
        wb(1'b1, OFS_CTRL, 32'h1);
        wb(1'b1, OFS_CLKDIV, 32'h5678);
        rd(OFS_CLKDIV, 32'h1234);
        chk({16'h0, div}, 32'h1234);
        wb(1'b1, 8'h40, 32'h5a5a);
        rd(8'h40, 32'h0);
        wb(1'b1, OFS_OWNADDR, 32'haa74);
    endtask : t_regs
    // Slave matches on both own addresses, check value, restart and disable
    task automatic t_slave();
        logic [7:0] c;
        wb(1'b1, OFS_CTRL, 32'h23);
        i2sst_peer_i.bus_start();
        i2sst_peer_i.send(1'b1, 8'hab);
        c = crc8(8'h00, 8'hab);
        rd(OFS_BUS_STATUS_TWO, {16'h0, c, 8'h86});
        i2sst_peer_i.send(1'b0, 8'h3c);
        c = crc8(c, 8'h3c);
        rd(OFS_BUS_STATUS_TWO, {16'h0, c, 8'h86});
        i2sst_peer_i.bus_start();
        rd(OFS_BUS_STATUS_TWO, 32'h2);
        wb(1'b1, OFS_CTRL, 32'h21);
        i2sst_peer_i.send(1'b1, 8'h75);
        rd(OFS_BUS_STATUS_TWO, 32'h6);
        wb(1'b1, OFS_CTRL, 32'h0);
        rd(OFS_BUS_STATUS_TWO, 32'h2);
        i2sst_peer_i.bus_stop();
        rd(OFS_BUS_STATUS_TWO, 32'h0);
    endtask : t_slave
    // Special addresses with their enables on and off
    task automatic t_special();
        logic [7:0] cfg [6] = '{8'h0d, 8'h05, 8'h09, 8'h01, 8'h11, 8'h01};
        logic [7:0] ab [6] = '{8'h10, 8'h10, 8'hc2, 8'hc2, 8'h00, 8'h00};
        logic [7:0] ex [6] = '{8'h42, 8'h02, 8'h22, 8'h02, 8'h12, 8'h02};
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, OFS_CTRL, {24'h0, cfg[i]});
            i2sst_peer_i.bus_start();
            i2sst_peer_i.send(1'b1, ab[i]);
            rd(OFS_BUS_STATUS_TWO, {24'h0, ex[i]});
            i2sst_peer_i.bus_stop();
            rd(OFS_BUS_STATUS_TWO, 32'h0);
        end
    endtask : t_special
    // Master role: set by start-sent, cleared by loss, stop and disable
    task automatic t_role();
        wb(1'b1, OFS_CTRL, 32'h1);
        i2sst_peer_i.bus_start();
        pulse(1'b1);
        chk({29'h0, busy, role, sent}, 32'h7);
        i2sst_peer_i.send(1'b1, 8'h40);
        rd(OFS_BUS_STATUS_TWO, 32'h7);
        i2sst_peer_i.lose();
        rd(OFS_BUS_STATUS_TWO, 32'h2);
        pulse(1'b0);
        pulse(1'b1);
        rd(OFS_BUS_STATUS_TWO, 32'h3);
        i2sst_peer_i.bus_stop();
        rd(OFS_BUS_STATUS_TWO, 32'h0);
        pulse(1'b0);
        pulse(1'b1);
        wb(1'b1, OFS_CTRL, 32'h0);
        // Disable reaches the flags one edge after ack, the output copies one more
        repeat (3) @(posedge mclk);
        chk({29'h0, busy, role, sent}, 32'h0);
        i2sst_peer_i.bus_start();
        chk({31'h0, busy}, 32'h1);
        i2sst_peer_i.bus_stop();
        rd(OFS_BUS_STATUS_TWO, 32'h0);
    endtask : t_role

    // Main sequence
    initial begin
        mclk = 1'b0;
        lclk = 1'b0;
        srst = 1'b1;
        start_gen = 1'b0;
        data_wr = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_slave();
        t_special();
        t_role();
        report_and_stop();
    end
    // Watchdog: the run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule : tb_top
